/* acp_pkg.sv */
// Package for the asynchronous control register port: widths, event bits,
// reset values and host timing counts.
// Assumes both ends run on one 40 MHz clock.
package acp_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 64;
	localparam int EVT_W = 8;
	// Register indices for the event cause and event mask registers
	localparam logic [5:0] EVENT_CAUSE_IDX = 6'h02;
	localparam logic [5:0] EVENT_MASK_IDX = 6'h03;
	// Bit of the host parity error flag in the event cause register
	localparam int HOST_PARITY_ERR_BIT = 0;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	localparam logic [7:0] MASK_RESET_VAL = 8'h00;
	// Settle count after acknowledge; unused, the host samples data in the cycle it first sees acknowledge low
	localparam int HOST_SETTLE_CYC = 1;
	// Host holds select high for at least this many cycles between cycles
	localparam int HOST_GAP_CYC = 2;
	localparam logic [1:0] HOST_GAP_CNT = 2'(HOST_GAP_CYC);
endpackage

/* acp_if.sv */
// Interface joining the device end and the host end of the port.
// Open-drain lines are resolved inside this interface from the enables.
`timescale 1ns/100ps
interface acp_if;
	logic sel_n;
	logic rd_not_wr;
	logic [5:0] reg_addr_lines;
	// Data lines: value, drive enable low means driving
	logic [7:0] dev_data;
	logic dev_data_oe_n;
	logic [7:0] host_data;
	logic host_data_oe_n;
	logic dev_par;
	logic dev_par_oe_n;
	logic host_par;
	logic host_par_oe_n;
	// Open-drain acknowledge and interrupt, pulled low when oe_n is low
	logic ack_oe_n;
	logic irq_oe_n;
	// Resolved bus values: device driver if enabled, else host driver, else pull-ups
	logic [7:0] reg_data_lines;
	logic bus_odd_parity;
	logic ack_n;
	logic irq_n;
	assign reg_data_lines = !dev_data_oe_n ? dev_data :
		(!host_data_oe_n ? host_data : 8'hFF);
	assign bus_odd_parity = !dev_par_oe_n ? dev_par :
		(!host_par_oe_n ? host_par : 1'b1);
	assign ack_n = ack_oe_n;
	assign irq_n = irq_oe_n;
	modport device (
		input sel_n, rd_not_wr, reg_addr_lines, reg_data_lines,
		input bus_odd_parity,
		output dev_data, dev_data_oe_n, dev_par, dev_par_oe_n,
		output ack_oe_n, irq_oe_n
	);
	modport host (
		output sel_n, rd_not_wr, reg_addr_lines,
		output host_data, host_data_oe_n, host_par, host_par_oe_n,
		input reg_data_lines, bus_odd_parity, ack_n, irq_n
	);
endinterface

/* acp_device.sv */
// Device end of the asynchronous control register port: 64 byte registers,
// odd parity check, acknowledge, event cause and mask, interrupt line.
// Assumes host pins arrive unsynchronised; one clock and async reset.
// Also assumes the host holds address, direction and data while selected.
// Notes on behaviour
// - Select low starts a read or write
// - Host presents valid lines while select low
// - Direction high reads, low writes
// - Acknowledge pulled low marks completion
// - Read data valid while acknowledge low
// - Host holds write data until acknowledge
// - Acknowledge stays low while select low
// - Interrupt line low on unmasked event
// - Each event bit individually maskable
// - Six address bits, top line is MSB
// - Parity line carries odd parity both ways
// - Read parity valid while acknowledge low
// - Host holds parity and data until acknowledge
// - Bad write parity blocks write, sets flag
// - Data bus driven on reads, sampled writes
// - Sixty-four eight-bit registers by address
// - Tolerate host changes unrelated to clock
`timescale 1ns/100ps
module acp_device (
	input wire logic clk_in,
	input wire logic resetn_in,
	acp_if.device port,
	input wire logic [acp_pkg::EVT_W-1:0] event_set_in,
	output logic [acp_pkg::NUM_REGS*acp_pkg::DATA_W-1:0] regs_out
);
	import acp_pkg::*;

	// Sequencer states: idle, settle after sync, acknowledge held
	typedef enum logic [1:0] {ACP_IDLE, ACP_SETTLE, ACP_ACK} acp_state_t;

	// Select synchroniser stages
	logic sel_meta_r, sel_sync_r;
	logic sel_meta_nxt, sel_sync_nxt;
	// Sequencer, acknowledge and read drive state
	acp_state_t state_r, state_nxt;
	logic ack_r, ack_nxt;
	logic drive_r, drive_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rpar_r, rpar_nxt;
	// Register file and its next contents
	logic [7:0] mem_r [NUM_REGS];
	logic [7:0] mem_nxt [NUM_REGS];
	// Interrupt line, write parity check and event sets
	logic irq_r, irq_nxt;
	logic par_ok;
	logic wr_fire;
	logic [7:0] cause_set;

	// Two-stage select synchroniser; only the second stage feeds the
	// sequencer, so a late select edge costs a cycle, never a half cycle
	always_comb begin
		sel_meta_nxt = ~port.sel_n;
		sel_sync_nxt = sel_meta_r;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sel_meta_r <= 1'b0;
			sel_sync_r <= 1'b0;
		end else begin
			sel_meta_r <= sel_meta_nxt;
			sel_sync_r <= sel_sync_nxt;
		end
	end

	// Odd parity: data bits and parity bit hold an odd count of ones
	// A write failing this check is still acknowledged
	assign par_ok = ^{port.reg_data_lines, port.bus_odd_parity};

	// Cycle sequencer: one settle cycle after sync so lines are stable
	// Address, direction and write data are read only in the settle
	// state, when the host has held them for several cycles; a select
	// withdrawn before that returns to idle with nothing done
	always_comb begin
		state_nxt = state_r;
		ack_nxt = ack_r;
		drive_nxt = drive_r;
		rdata_nxt = rdata_r;
		rpar_nxt = rpar_r;
		wr_fire = 1'b0;
		case (state_r)
			ACP_IDLE: begin
				if (sel_sync_r) begin
					state_nxt = ACP_SETTLE;
				end
			end
			ACP_SETTLE: begin
				if (!sel_sync_r) begin
					state_nxt = ACP_IDLE;
				end else begin
					state_nxt = ACP_ACK;
					ack_nxt = 1'b1;
					if (port.rd_not_wr) begin
						drive_nxt = 1'b1;
						rdata_nxt = mem_r[port.reg_addr_lines];
						rpar_nxt = ~^mem_r[port.reg_addr_lines];
					end else begin
						wr_fire = 1'b1;
					end
				end
			end
			ACP_ACK: begin
				if (!sel_sync_r) begin
					state_nxt = ACP_IDLE;
					ack_nxt = 1'b0;
					drive_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ACP_IDLE;
				ack_nxt = 1'b0;
				drive_nxt = 1'b0;
			end
		endcase
	end

	// Sequencer registers; read data and parity stay frozen until release
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= ACP_IDLE;
			ack_r <= 1'b0;
			drive_r <= 1'b0;
			rdata_r <= REG_RESET_VAL;
			rpar_r <= ~^REG_RESET_VAL;
		end else begin
			state_r <= state_nxt;
			ack_r <= ack_nxt;
			drive_r <= drive_nxt;
			rdata_r <= rdata_nxt;
			rpar_r <= rpar_nxt;
		end
	end

	// Hardware events, including a rejected write, feed the cause register
	// Event inputs are levels: each cycle held sets the cause bit again
	always_comb begin
		cause_set = event_set_in;
		if (wr_fire && !par_ok) begin
			cause_set[HOST_PARITY_ERR_BIT] = 1'b1;
		end
	end

	// Register file; cause bits clear by writing one, set wins over clear
	// A hardware set in the same cycle as a host clear wins
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (wr_fire && par_ok) begin
			if (port.reg_addr_lines == EVENT_CAUSE_IDX) begin
				mem_nxt[EVENT_CAUSE_IDX] =
					mem_r[EVENT_CAUSE_IDX] & ~port.reg_data_lines;
			end else begin
				mem_nxt[port.reg_addr_lines] = port.reg_data_lines;
			end
		end
		mem_nxt[EVENT_CAUSE_IDX] = mem_nxt[EVENT_CAUSE_IDX] | cause_set;
	end

	// Register file storage, cleared by reset
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				mem_r[i] <= REG_RESET_VAL;
			end
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	end

	// Interrupt when any unmasked cause bit is set; mask bit 1 passes it
	always_comb begin
		irq_nxt = |(mem_r[EVENT_CAUSE_IDX] & mem_r[EVENT_MASK_IDX]);
	end

	// Registered so the open-drain interrupt line never glitches
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Flatten register contents for the device's own logic
	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : g_flat
			assign regs_out[g*DATA_W +: DATA_W] = mem_r[g];
		end
	endgenerate

	// Pin drivers; enable low means the line is driven or pulled low
	// Acknowledge and read drive change on the same edge, so the host
	// never sees acknowledge low while the data lines float
	assign port.dev_data = rdata_r;
	assign port.dev_par = rpar_r;
	assign port.dev_data_oe_n = ~drive_r;
	assign port.dev_par_oe_n = ~drive_r;
	assign port.ack_oe_n = ~ack_r;
	assign port.irq_oe_n = ~irq_r;
endmodule

/* acp_host.sv */
// Host end of the asynchronous control register port: runs one read or
// write per request, generates odd parity, waits for acknowledge.
// Assumes the device end sits on the same interface and clock.
`timescale 1ns/100ps
module acp_host (
	input wire logic clk_in,
	input wire logic resetn_in,
	acp_if.host port,
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic req_read_in,
	input wire logic [acp_pkg::ADDR_W-1:0] req_addr_in,
	input wire logic [acp_pkg::DATA_W-1:0] req_wdata_in,
	input wire logic req_bad_parity_in,
	output logic done_out,
	output logic [acp_pkg::DATA_W-1:0] rdata_out,
	output logic rpar_ok_out,
	output logic irq_out
);
	import acp_pkg::*;

	typedef enum logic [1:0] {ACH_IDLE, ACH_WAIT, ACH_RELEASE, ACH_GAP}
		ach_state_t;

	ach_state_t state_r, state_nxt;
	logic sel_r, sel_nxt;
	logic rd_r, rd_nxt;
	logic [5:0] addr_r, addr_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic wpar_r, wpar_nxt;
	logic done_r, done_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rok_r, rok_nxt;
	logic [1:0] gap_r, gap_nxt;

	// Request sequencer: select, wait for acknowledge, deselect, gap
	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		rd_nxt = rd_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		wpar_nxt = wpar_r;
		done_nxt = 1'b0;
		rdata_nxt = rdata_r;
		rok_nxt = rok_r;
		gap_nxt = gap_r;
		case (state_r)
			ACH_IDLE: begin
				if (req_valid_in) begin
					state_nxt = ACH_WAIT;
					sel_nxt = 1'b1;
					rd_nxt = req_read_in;
					addr_nxt = req_addr_in;
					wdata_nxt = req_wdata_in;
					wpar_nxt = ~^req_wdata_in ^ req_bad_parity_in;
				end
			end
			ACH_WAIT: begin
				if (!port.ack_n) begin
					state_nxt = ACH_RELEASE;
					rdata_nxt = port.reg_data_lines;
					rok_nxt = ^{port.reg_data_lines, port.bus_odd_parity};
				end
			end
			ACH_RELEASE: begin
				sel_nxt = 1'b0;
				done_nxt = 1'b1;
				gap_nxt = HOST_GAP_CNT;
				state_nxt = ACH_GAP;
			end
			ACH_GAP: begin
				if (gap_r != 2'h0) begin
					gap_nxt = gap_r - 2'h1;
				end else if (port.ack_n) begin
					state_nxt = ACH_IDLE;
				end
			end
			default: begin
				state_nxt = ACH_IDLE;
				sel_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= ACH_IDLE;
			sel_r <= 1'b0;
			rd_r <= 1'b1;
			addr_r <= 6'h00;
			wdata_r <= 8'h00;
			wpar_r <= 1'b1;
			done_r <= 1'b0;
			rdata_r <= 8'h00;
			rok_r <= 1'b0;
			gap_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			rd_r <= rd_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			wpar_r <= wpar_nxt;
			done_r <= done_nxt;
			rdata_r <= rdata_nxt;
			rok_r <= rok_nxt;
			gap_r <= gap_nxt;
		end
	end

	// Host pins; data and parity held for the whole select of a write
	assign port.sel_n = ~sel_r;
	assign port.rd_not_wr = rd_r;
	assign port.reg_addr_lines = addr_r;
	assign port.host_data = wdata_r;
	assign port.host_par = wpar_r;
	assign port.host_data_oe_n = ~(sel_r & ~rd_r);
	assign port.host_par_oe_n = ~(sel_r & ~rd_r);

	// User side
	assign req_ready_out = (state_r == ACH_IDLE);
	assign done_out = done_r;
	assign rdata_out = rdata_r;
	assign rpar_ok_out = rok_r;
	assign irq_out = ~port.irq_n;
endmodule

/* acp_asserts.sv */
// Checker on the port wires: acknowledge timing, read drive, release.
// Assumes it watches the interface joining the device and host ends.
`timescale 1ns/100ps
module acp_asserts (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic sel_n,
	input wire logic rd_not_wr,
	input wire logic [7:0] reg_data_lines,
	input wire logic bus_odd_parity,
	input wire logic ack_n,
	input wire logic dev_data_oe_n,
	input wire logic dev_par_oe_n
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	// Select passes the synchroniser, then acknowledge follows
	a_sel_to_ack: assert property (
		$fell(sel_n) |-> ack_n[*3] ##[1:3] !ack_n)
		else $error("acknowledge timing after select wrong");
	a_ack_hold_sel: assert property (
		!ack_n && !sel_n |=> !ack_n)
		else $error("acknowledge released while selected");
	a_ack_cause: assert property (
		$fell(ack_n) |-> !sel_n)
		else $error("acknowledge without select");
	a_read_drive_on: assert property (
		!ack_n && rd_not_wr && !sel_n |-> !dev_data_oe_n && !dev_par_oe_n)
		else $error("read data or parity not driven");
	a_read_par_odd: assert property (
		!ack_n && rd_not_wr && !sel_n |-> ^{reg_data_lines, bus_odd_parity})
		else $error("read parity not odd");
	a_write_no_drive: assert property (
		!ack_n && !rd_not_wr && !sel_n |-> dev_data_oe_n && dev_par_oe_n)
		else $error("device drives bus on write");
	a_release_lines: assert property (
		sel_n[*5] |-> ack_n && dev_data_oe_n && dev_par_oe_n)
		else $error("lines held after deselect");
	a_ack_release: assert property (
		$rose(sel_n) |-> ##[1:4] ack_n)
		else $error("acknowledge not released");
endmodule

/* test_async_control_register_port.sv */
// Testbench: host and device ends joined, driven from the host user side.
// Assumes one 40 MHz clock; a register model predicts every result.
`timescale 1ns/100ps
module test_async_control_register_port;
	import acp_pkg::*;
	logic clk_in = 0;
	logic resetn_in = 0;
	logic req_valid_in = 0;
	logic req_read_in = 0;
	logic req_bad_parity_in = 0;
	logic [5:0] req_addr_in = 0;
	logic [7:0] req_wdata_in = 0;
	logic [7:0] event_set_in = 0;
	logic req_ready_out, done_out, rpar_ok_out, irq_out;
	logic [7:0] rdata_out;
	logic [NUM_REGS*DATA_W-1:0] regs_out;
	logic [7:0] mem [NUM_REGS];
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	acp_if bus ();
	acp_device i_acp_device (.clk_in, .resetn_in, .port(bus),
		.event_set_in, .regs_out);
	acp_host i_acp_host (.clk_in, .resetn_in, .port(bus), .req_valid_in,
		.req_ready_out, .req_read_in, .req_addr_in, .req_wdata_in,
		.req_bad_parity_in, .done_out, .rdata_out, .rpar_ok_out, .irq_out);
	acp_asserts i_acp_asserts (.clk_in, .resetn_in, .sel_n(bus.sel_n),
		.rd_not_wr(bus.rd_not_wr), .reg_data_lines(bus.reg_data_lines),
		.bus_odd_parity(bus.bus_odd_parity), .ack_n(bus.ack_n),
		.dev_data_oe_n(bus.dev_data_oe_n), .dev_par_oe_n(bus.dev_par_oe_n));
	// Clock and cycle ceiling
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			results();
		end
	end
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One host request, then model update and full comparison
	task automatic op(logic rd, logic [5:0] a, logic [7:0] d, logic bad);
		int n;
		logic irq_exp;
		n = 0;
		while (req_ready_out !== 1'b1 && n < 50) begin
			@(negedge clk_in);
			n++;
		end
		req_valid_in = 1;
		req_read_in = rd;
		req_addr_in = a;
		req_wdata_in = d;
		req_bad_parity_in = bad;
		@(negedge clk_in);
		req_valid_in = 0;
		n = 0;
		while (done_out !== 1'b1 && n < 50) begin
			@(negedge clk_in);
			n++;
		end
		check("done", {7'h0, done_out}, 8'h01);
		if (rd) begin
			check("rdata", rdata_out, mem[a]);
			check("rpar", {7'h0, rpar_ok_out}, 8'h01);
		end else if (bad)
			mem[EVENT_CAUSE_IDX][HOST_PARITY_ERR_BIT] = 1'b1;
		else if (a == EVENT_CAUSE_IDX)
			mem[a] = mem[a] & ~d;
		else
			mem[a] = d;
		// Acknowledge clears three edges after deselect (sync, then state)
		repeat (3) @(negedge clk_in);
		irq_exp = |(mem[EVENT_CAUSE_IDX] & mem[EVENT_MASK_IDX]);
		check("irq", {7'h0, irq_out}, {7'h0, irq_exp});
		check("ack_idle", {7'h0, bus.ack_n}, 8'h01);
		for (int i = 0; i < NUM_REGS; i++)
			check("reg", regs_out[8*i+:8], mem[i]);
	endtask
	// Main sequence
	initial begin
		void'($urandom(26));
		foreach (mem[i])
			mem[i] = REG_RESET_VAL;
		repeat (20) @(negedge clk_in);
		resetn_in = 1;
		@(negedge clk_in);
		check("sel_idle", {7'h0, bus.sel_n}, 8'h01);
		check("irq_idle", {7'h0, bus.irq_n}, 8'h01);
		// Address boundaries, then random traffic
		op(0, 6'h00, 8'hFF, 0);
		op(0, 6'h3F, 8'h01, 0);
		op(0, 6'h20, 8'h80, 0);
		op(1, 6'h00, 8'h00, 0);
		op(1, 6'h3F, 8'h00, 0);
		for (int i = 0; i < 40; i++)
			op(1'($urandom), 6'($urandom), 8'($urandom), 0);
		// Bad parity write blocked and flagged, then mask and clear
		op(0, 6'h05, 8'h3C, 0);
		op(0, 6'h05, 8'hA5, 1);
		op(1, 6'h05, 8'h00, 0);
		op(1, EVENT_CAUSE_IDX, 8'h00, 0);
		op(0, EVENT_MASK_IDX, 8'h01, 0);
		op(0, EVENT_MASK_IDX, 8'h00, 0);
		op(0, EVENT_CAUSE_IDX, 8'h01, 0);
		// External event raises, mask gates, clear drops
		event_set_in = 8'h10;
		@(negedge clk_in);
		event_set_in = 8'h00;
		mem[EVENT_CAUSE_IDX] = mem[EVENT_CAUSE_IDX] | 8'h10;
		op(0, EVENT_MASK_IDX, 8'h10, 0);
		op(1, EVENT_CAUSE_IDX, 8'h00, 0);
		op(0, EVENT_CAUSE_IDX, 8'h10, 0);
		// Mid-run reset clears every register and releases the lines
		resetn_in = 0;
		repeat (3) @(negedge clk_in);
		resetn_in = 1;
		foreach (mem[i])
			mem[i] = REG_RESET_VAL;
		@(negedge clk_in);
		check("ack_rst", {7'h0, bus.ack_n}, 8'h01);
		check("sel_rst", {7'h0, bus.sel_n}, 8'h01);
		op(1, 6'h05, 8'h00, 0);
		results();
	end
endmodule
